// [rtl/fst_pkg.sv]
// package: status word, tag word and condition code definitions
package fst_pkg;
   // status word field positions
   localparam int ST_IE = 0;
   localparam int ST_PE = 5;
   localparam int ST_SF = 6;
   localparam int ST_ES = 7;
   localparam int ST_C0 = 8;
   localparam int ST_C1 = 9;
   localparam int ST_C2 = 10;
   localparam int ST_TOP_LSB = 11;
   localparam int ST_C3 = 14;
   localparam int ST_BUSY = 15;
   localparam int EXC_W = 6;
   localparam int TAG_W = 2;
   // reset values
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] TAG_RST = 16'hffff;
   localparam logic [5:0] MASK_RST = 6'h3f;
   // tag encodings
   localparam logic [1:0] TAG_VALID = 2'h0;
   localparam logic [1:0] TAG_ZERO = 2'h1;
   localparam logic [1:0] TAG_SPECIAL = 2'h2;
   localparam logic [1:0] TAG_EMPTY = 2'h3;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_PARTIAL_REMAINDER = 4'h1,
      OP_IEEE_REMAINDER = 4'h2,
      OP_PARTIAL_TANGENT = 4'h3,
      OP_SINE = 4'h4,
      OP_COSINE = 4'h5,
      OP_SINE_COSINE = 4'h6,
      OP_COMPARE = 4'h7,
      OP_ROUNDING = 4'h8,
      OP_LOAD = 4'h9
   } fst_op_t;

   typedef enum logic [2:0] {
      VK_NORMAL = 3'h0,
      VK_ZERO = 3'h1,
      VK_QNAN = 3'h2,
      VK_SNAN = 3'h3,
      VK_INFINITY = 3'h4,
      VK_DENORMAL = 3'h5,
      VK_UNSUPPORTED = 3'h6,
      VK_EMPTY = 3'h7
   } fst_vkind_t;

   // outcome of one executed instruction, reported by the datapath
   typedef struct packed {
      logic [5:0] exc;
      logic stack_fault;
      logic stack_over;
      logic round_up;
      logic [2:0] quot;
      logic rem_done;
      logic too_large;
      logic cmp_less;
      logic cmp_equal;
      logic cmp_unord;
   } fst_result_t;

   function automatic logic [1:0] tag_encode(input fst_vkind_t k);
      unique case (k)
         VK_NORMAL: tag_encode = TAG_VALID;
         VK_ZERO: tag_encode = TAG_ZERO;
         VK_EMPTY: tag_encode = TAG_EMPTY;
         default: tag_encode = TAG_SPECIAL;
      endcase
   endfunction

   function automatic logic is_trig(input fst_op_t op);
      is_trig = (op == OP_PARTIAL_TANGENT) || (op == OP_SINE) ||
         (op == OP_COSINE) || (op == OP_SINE_COSINE);
   endfunction

   function automatic logic is_rem(input fst_op_t op);
      is_rem = (op == OP_PARTIAL_REMAINDER) || (op == OP_IEEE_REMAINDER);
   endfunction
endpackage

// [rtl/fst_cond_gen.sv]
// condition code generator: new c3..c0 values and write enables per op
module fst_cond_gen
   import fst_pkg::*;
(
   input wire fst_pkg::fst_op_t op,
   input wire fst_pkg::fst_result_t res,
   output logic [3:0] cc_val,
   output logic [3:0] cc_wr
);
   // bit order of cc_val / cc_wr is {c3, c2, c1, c0}
   logic stack_exc;

   always_comb begin
      // stale results on an idle cycle must not touch c1
      stack_exc = (op != OP_NONE) & res.exc[ST_IE] & res.stack_fault;
      cc_val = 4'h0;
      cc_wr = 4'h0;
      // bits not written keep their old value: undefined bits are left alone
      if (is_rem(op)) begin
         cc_val[2] = ~res.rem_done;
         cc_wr[2] = 1'b1;
         if (res.rem_done) begin
            cc_val[0] = res.quot[2];
            cc_val[3] = res.quot[1];
            cc_val[1] = res.quot[0];
            cc_wr = 4'hf;
         end
      end else if (is_trig(op)) begin
         cc_val[2] = res.too_large;
         cc_wr[2] = 1'b1;
         if (!res.too_large) begin
            cc_val[1] = res.round_up & res.exc[ST_PE];
            cc_wr[1] = 1'b1;
         end
      end else if (op == OP_COMPARE) begin
         cc_wr = 4'hf;
         if (res.cmp_unord) begin
            cc_val = 4'hd;
         end else if (res.cmp_equal) begin
            cc_val = 4'h8;
         end else if (res.cmp_less) begin
            cc_val = 4'h1;
         end
      end else if (op == OP_ROUNDING) begin
         cc_val[1] = res.round_up & res.exc[ST_PE];
         cc_wr[1] = 1'b1;
      end else if (op == OP_LOAD) begin
         cc_wr[1] = 1'b1;
      end
      // a stack exception turns c1 into the overflow/underflow indicator
      if (stack_exc) begin
         cc_val[1] = res.stack_over;
         cc_wr[1] = 1'b1;
      end
   end
endmodule // fst_cond_gen

// [rtl/fst_status.sv]
// status word, tag word, exception flags and error output

module fst_status (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire fst_pkg::fst_op_t op_code,
   input wire fst_pkg::fst_result_t op_res,
   input wire logic exc_clear,
   input wire logic tag_we,
   input wire logic [2:0] tag_index,
   input wire fst_pkg::fst_vkind_t tag_kind,
   input wire logic top_we,
   input wire logic [2:0] top_value,
   input wire logic ctrl_we,
   input wire logic [15:0] ctrl_word,
   input wire logic env_load,
   input wire logic [15:0] env_status,
   input wire logic [15:0] env_tag,
   output logic [15:0] status_word,
   output logic [15:0] stack_tag_word,
   output logic error_n,
   output logic operand_hold
);
   import fst_pkg::*;

   logic [5:0] exc_reg;
   logic [5:0] exc_next;
   logic sf_reg;
   logic sf_next;
   logic [5:0] mask_reg;
   logic [5:0] mask_next;
   logic [3:0] cc_reg;
   logic [3:0] cc_next;
   logic [2:0] top_reg;
   logic [2:0] top_next;
   logic [15:0] tag_reg;
   logic [15:0] status_reg;
   logic error_n_reg;
   logic hold_reg;
   logic es_next;
   logic [3:0] cc_val;
   logic [3:0] cc_wr;
   fst_op_t op_eff;

   assign op_eff = op_valid ? op_code : OP_NONE;

   fst_cond_gen u_cond (
      .op(op_eff),
      .res(op_res),
      .cc_val(cc_val),
      .cc_wr(cc_wr)
   );

   // next values; an environment load overrides everything except the mask write
   always_comb begin
      mask_next = ctrl_we ? ctrl_word[5:0] : mask_reg;
      if (env_load) begin
         exc_next = env_status[5:0];
         sf_next = env_status[ST_SF];
         cc_next = {env_status[ST_C3], env_status[ST_C2],
            env_status[ST_C1], env_status[ST_C0]};
         top_next = env_status[ST_TOP_LSB +: 3];
      end else begin
         // set wins over a clear in the same cycle
         exc_next = (exc_clear ? 6'h00 : exc_reg) |
            (op_valid ? op_res.exc : 6'h00);
         sf_next = (exc_clear ? 1'b0 : sf_reg) |
            (op_valid & op_res.stack_fault);
         cc_next = (cc_reg & ~cc_wr) | (cc_val & cc_wr);
         top_next = top_we ? top_value : top_reg;
      end
      // loaded summary and busy bits are ignored and rebuilt here
      es_next = |(exc_next & ~mask_next);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         exc_reg <= 6'h00;
         sf_reg <= 1'b0;
         cc_reg <= 4'h0;
         top_reg <= 3'h0;
      end else begin
         exc_reg <= exc_next;
         sf_reg <= sf_next;
         cc_reg <= cc_next;
         top_reg <= top_next;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= MASK_RST;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // tags sit at physical slots; top is only reported, never applied
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tag_reg <= TAG_RST;
      end else if (env_load) begin
         tag_reg <= env_tag;
      end else if (tag_we) begin
         tag_reg[TAG_W*tag_index +: TAG_W] <= tag_encode(tag_kind);
      end
   end

   // image assembled from next values so the outputs carry no extra lag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_reg <= STATUS_RST;
      end else begin
         status_reg <= {es_next, cc_next[3], top_next, cc_next[2],
            cc_next[1], cc_next[0], es_next, sf_next, exc_next};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         error_n_reg <= 1'b1;
      end else begin
         error_n_reg <= ~es_next;
      end
   end

   // tells the datapath to leave an oversized trig operand at the top
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hold_reg <= 1'b0;
      end else begin
         hold_reg <= op_valid & is_trig(op_code) & op_res.too_large;
      end
   end

   assign status_word = status_reg;
   assign stack_tag_word = tag_reg;
   assign error_n = error_n_reg;
   assign operand_hold = hold_reg;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_error_tracks_es: assert property (
      error_n_reg == ~status_reg[ST_ES])
      else $error("error output disagrees with summary bit");

   a_busy_mirror_es: assert property (
      status_reg[ST_BUSY] == status_reg[ST_ES])
      else $error("busy mirror differs from summary bit");

   a_es_from_flags: assert property (
      status_reg[ST_ES] == |(status_reg[5:0] & ~mask_reg))
      else $error("summary bit not the or of unmasked flags");

   a_env_es_rebuilt: assert property (
      env_load && !ctrl_we |=> status_reg[5:0] == $past(env_status[5:0])
      && status_reg[ST_ES] == |($past(env_status[5:0]) & ~mask_reg))
      else $error("summary bit not rebuilt after environment load");

   a_env_error_now: assert property (
      env_load && !ctrl_we && |(env_status[5:0] & ~mask_reg)
      |=> !error_n_reg)
      else $error("error output late after environment load");

   a_exc_sticky: assert property (
      op_valid && !env_load |=>
      (status_reg[5:0] & $past(op_res.exc)) == $past(op_res.exc))
      else $error("exception flag not set by instruction");

   a_exc_hold: assert property (
      !op_valid && !env_load && !exc_clear |=> $stable(status_reg[5:0]))
      else $error("exception flags changed with no event");

   a_cc_idle: assert property (
      !op_valid && !env_load
      |=> $stable(status_reg[10:8]) && $stable(status_reg[ST_C3]))
      else $error("condition bits changed with no instruction");

   a_stack_c1: assert property (
      op_valid && !env_load && op_res.exc[ST_IE] && op_res.stack_fault
      |=> status_reg[ST_C1] == $past(op_res.stack_over))
      else $error("c1 does not show stack direction");

   a_rem_c2: assert property (
      op_valid && !env_load && is_rem(op_code)
      |=> status_reg[ST_C2] == !$past(op_res.rem_done))
      else $error("c2 wrong after remainder");

   a_rem_quot: assert property (
      op_valid && !env_load && is_rem(op_code) && op_res.rem_done &&
      !(op_res.exc[ST_IE] && op_res.stack_fault)
      |=> {status_reg[ST_C0], status_reg[ST_C3], status_reg[ST_C1]}
      == $past(op_res.quot))
      else $error("quotient bits wrong after remainder");

   a_trig_hold: assert property (
      op_valid && !env_load && is_trig(op_code) && op_res.too_large
      |=> operand_hold && status_reg[ST_C2] ##1
      (!operand_hold || $past(op_valid)))
      else $error("oversized trig operand not held");

   a_cmp_unord: assert property (
      op_valid && !env_load && op_code == OP_COMPARE && op_res.cmp_unord
      |=> {status_reg[ST_C3], status_reg[ST_C2], status_reg[ST_C0]}
      == 3'b111)
      else $error("unordered compare not reported");

   a_round_c1: assert property (
      op_valid && !env_load && op_code == OP_ROUNDING &&
      !(op_res.exc[ST_IE] && op_res.stack_fault)
      |=> status_reg[ST_C1] ==
      ($past(op_res.round_up) && status_reg[ST_PE]))
      else $error("c1 does not show round up");

   a_tag_slot: assert property (
      tag_we && !env_load |=>
      tag_reg[TAG_W*$past(tag_index) +: TAG_W] == tag_encode($past(tag_kind)))
      else $error("tag slot not written with encoded class");
endmodule // fst_status

// [tb/fst_host_model.sv]
// host cpu model: exception handler that clears flags after an error
module fst_host_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic error_n,
   input wire logic hnd_en,
   input wire logic slow,
   output logic exc_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] wait_reg;
   // slow handler models a long interrupt path before the clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wait_reg <= 5'h0;
         exc_clear <= 1'b0;
      end else begin
         exc_clear <= 1'b0;
         if (!error_n && hnd_en && !exc_clear) begin
            wait_reg <= wait_reg + 5'h1;
            if (wait_reg >= (slow ? 5'h13 : 5'h0)) begin
               exc_clear <= 1'b1;
               wait_reg <= 5'h0;
            end
         end
      end
   end
endmodule // fst_host_model

// [tb/test_fst_status.sv]
// self-checking bench for the status, tag and condition logic
module test_fst_status;
   import fst_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rst, op_valid, tag_we, top_we, ctrl_we, env_load;
   fst_op_t op_code;
   fst_result_t op_res;
   fst_vkind_t tag_kind;
   logic [2:0] tag_index, top_value;
   logic [15:0] ctrl_word, env_status, env_tag, status_word, stack_tag_word;
   logic error_n, operand_hold, exc_clear, hnd_en, slow;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [4:0] cf [4] = '{5'h01, 5'h02, 5'h04, 5'h00};
   logic [3:0] ce [4] = '{4'hd, 4'h8, 4'h1, 4'h0};

   fst_status u_fst_status (.ref_clk, .rst, .op_valid, .op_code, .op_res,
      .exc_clear, .tag_we, .tag_index, .tag_kind, .top_we, .top_value,
      .ctrl_we, .ctrl_word, .env_load, .env_status, .env_tag, .status_word,
      .stack_tag_word, .error_n, .operand_hold);
   fst_host_model u_fst_host_model (.ref_clk, .rst, .error_n, .hnd_en,
      .slow, .exc_clear);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // a hang is cut short well past the expected run of about 140 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // condition nibble c3 c2 c1 c0
   function automatic logic [15:0] cc();
      return {12'h000, status_word[ST_C3], status_word[ST_C2],
         status_word[ST_C1], status_word[ST_C0]};
   endfunction

   task automatic op(input fst_op_t c, input logic [5:0] e,
         input logic [2:0] f3, q, input logic [4:0] f5);
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_res <= {e, f3, q, f5};
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
   endtask

   // s = {tag, top, ctrl, env} strobes
   task automatic str(input logic [3:0] s, input logic [15:0] a, b);
      @(posedge ref_clk);
      {tag_we, top_we, ctrl_we, env_load} <= s;
      tag_index <= a[2:0];
      tag_kind <= fst_vkind_t'(a[5:3]);
      top_value <= a[2:0];
      ctrl_word <= a;
      env_status <= b;
      env_tag <= b ^ 16'h1234;
      @(posedge ref_clk);
      {tag_we, top_we, ctrl_we, env_load} <= 4'h0;
      #1;
   endtask

   task automatic hnd(input logic s);
      @(posedge ref_clk);
      slow <= s;
      hnd_en <= 1'b1;
      for (int i = 0; i < 40 && error_n !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      @(posedge ref_clk);
      hnd_en <= 1'b0;
      #1;
      chk({15'h0, error_n}, 16'h0001);
   endtask

   initial begin
      rst = 1'b1;
      {op_valid, tag_we, top_we, ctrl_we, env_load, hnd_en, slow} = '0;
      op_code = OP_NONE;
      op_res = '0;
      tag_kind = VK_NORMAL;
      {tag_index, top_value, ctrl_word, env_status, env_tag} = '0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk(status_word, 16'h0000);
      chk(stack_tag_word, 16'hffff);
      chk({15'h0, error_n}, 16'h0001);
      for (int k = 0; k < 8; k++) str(4'h8, 16'(k * 9), 16'h0);
      chk(stack_tag_word, 16'heaa4);
      str(4'h4, 16'h0003, 16'h0);
      chk(status_word, 16'h1800);
      chk(stack_tag_word, 16'heaa4);
      str(4'h2, 16'h0000, 16'h0);
      op(OP_LOAD, 6'h01, 3'b110, 3'h0, 5'h00);
      chk(status_word, 16'h9ac1);
      chk({15'h0, error_n}, 16'h0000);
      hnd(1'b1);
      chk(status_word, 16'h1a00);
      op(OP_LOAD, 6'h01, 3'b100, 3'h0, 5'h00);
      chk(status_word, 16'h98c1);
      hnd(1'b0);
      chk(status_word, 16'h1800);
      str(4'h2, 16'h003f, 16'h0);
      for (int q = 0; q < 8; q++) begin
         op(q[0] ? OP_IEEE_REMAINDER : OP_PARTIAL_REMAINDER, 6'h0, 3'h0,
            3'(q), 5'h10);
         chk(cc(), {12'h0, q[1], 1'b0, q[0], q[2]});
      end
      op(OP_PARTIAL_REMAINDER, 6'h0, 3'h0, 3'h5, 5'h00);
      chk(cc(), 16'h000f);
      for (int c = 3; c < 7; c++) begin
         op(fst_op_t'(c), 6'h20, 3'b001, 3'h0, 5'h08);
         chk(cc() & 16'h0004, 16'h0004);
         chk({15'h0, operand_hold}, 16'h0001);
         op(fst_op_t'(c), 6'h20, 3'b001, 3'h0, 5'h00);
         chk(cc() & 16'h0006, 16'h0002);
         chk({15'h0, operand_hold}, 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         op(OP_COMPARE, 6'h0, 3'h0, 3'h0, cf[i]);
         chk(cc(), {12'h0, ce[i]});
      end
      for (int r = 0; r < 2; r++) begin
         op(OP_ROUNDING, 6'h20, {2'b00, r[0]}, 3'h0, 5'h00);
         chk(cc() & 16'h0002, {14'h0, r[0], 1'b0});
      end
      str(4'hb, 16'h003f, 16'h8085);
      chk(status_word, 16'h0005);
      chk(stack_tag_word, 16'h92b1);
      chk({15'h0, error_n}, 16'h0001);
      str(4'h3, 16'h003e, 16'h0001);
      chk(status_word, 16'h8081);
      chk({15'h0, error_n}, 16'h0000);
      hnd(1'b1);
      chk(status_word, 16'h0000);
      test_done();
   end
endmodule // test_fst_status
